// *** logic/pac_accum.sv ***
/*
 * pac_accum: pulse accumulator on the channel 7 pin, the timer counter
 * clock select and the capture/compare value registers of all channels.
 * Assumes: prescaler ticks, free-running count and capture strobes come
 * from logic on core_clk_i; only channel7_pin_i is asynchronous.
 */
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module pac_accum
	import pac_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [PAC_ADDR_W-1:0] reg_addr_i,
	input wire logic [PAC_VAL_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [PAC_VAL_W-1:0] reg_rdata_o,
	input wire logic channel7_pin_i,
	input wire logic prescale_tick_i,
	input wire logic div64_tick_i,
	input wire logic [PAC_VAL_W-1:0] timer_count_i,
	input wire logic [NUM_CH-1:0] capture_strobe_i,
	output logic [NUM_CH*PAC_VAL_W-1:0] channel_value_o,
	output logic [NUM_CH-1:0] channel_direction_o,
	output logic main_timer_enable_o,
	output logic timer_count_tick_o,
	output logic accum_clock_o,
	output logic irq_o
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic pin_prev;
		logic [7:0] ctrl;
		logic main_timer_enable;
		logic fast_flag_clear;
		logic [NUM_CH-1:0] dir;
		logic [PAC_VAL_W-1:0] count;
		logic [1:0] flags;
		logic [PAC_VAL_W-1:0] div_cnt;
		logic [PAC_VAL_W-1:0] rdata;
		logic [NUM_CH-1:0][PAC_VAL_W-1:0] value;
	} pac_state_type;

	pac_state_type s;
	pac_state_type next_s;

	logic accum_enable;
	logic accum_mode_select;
	logic accum_polarity;
	pac_clksel_type clksel;
	logic pin_rise;
	logic pin_fall;
	logic sel_edge;
	logic gate_active;
	logic div64_ok;
	logic accum_clock;
	logic count_wr;
	logic count_access;
	logic overflow;
	logic tick256;
	logic tick65536;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic [NUM_CH-1:0] chan_hit;
	logic [NUM_CH-1:0][PAC_VAL_W-1:0] next_value;

	assign accum_enable = s.ctrl[PAC_EN_BIT];
	assign accum_mode_select = s.ctrl[PAC_MODE_BIT];
	assign accum_polarity = s.ctrl[PAC_POL_BIT];
	assign clksel = pac_clksel_type'(s.ctrl[PAC_CLK_HI:PAC_CLK_LO]);

	// only the second synchroniser stage and its delayed copy are looked at
	assign pin_rise = s.sync2 & ~s.pin_prev;
	assign pin_fall = ~s.sync2 & s.pin_prev;
	// counting edge and trailing gate edge share the same polarity mapping
	assign sel_edge = accum_polarity ? pin_rise : pin_fall;
	assign gate_active = accum_polarity ? ~s.sync2 : s.sync2;
	assign div64_ok = div64_tick_i & s.main_timer_enable;
	assign accum_clock = accum_enable & (accum_mode_select ?
		(gate_active & div64_ok) : sel_edge);

	assign count_wr = reg_wr_i & (reg_addr_i == PAC_COUNT_ADDR);
	assign count_access = count_wr |
		(reg_rd_i & (reg_addr_i == PAC_COUNT_ADDR));
	// a software write of the count in the same cycle suppresses the wrap
	assign overflow = accum_clock & ~count_wr &
		(s.count == PAC_COUNT_MAX);

	assign tick256 = accum_clock &
		(s.div_cnt[PAC_DIV256_W-1:0] == PAC_DIV256_MAX);
	assign tick65536 = accum_clock & (s.div_cnt == PAC_COUNT_MAX);

	assign flag_set[PAC_OVF_BIT] = overflow;
	assign flag_set[PAC_IN_BIT] = accum_enable & sel_edge;
	always_comb begin
		flag_clr = 2'b00;
		if (reg_wr_i && reg_addr_i == PAC_FLAG_ADDR) begin
			flag_clr = reg_wdata_i[1:0];
		end
		if (s.fast_flag_clear && count_access) begin
			flag_clr = 2'b11;
		end
	end

	// selector is pure combinational logic on the stored field
	always_comb begin
		timer_count_tick_o = prescale_tick_i;
		if (accum_enable) begin
			case (clksel)
			PAC_CLK_PRESCALE: timer_count_tick_o = prescale_tick_i;
			PAC_CLK_ACCUM: timer_count_tick_o = accum_clock;
			PAC_CLK_DIV256: timer_count_tick_o = tick256;
			PAC_CLK_DIV65536: timer_count_tick_o = tick65536;
			default: timer_count_tick_o = prescale_tick_i;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
			localparam logic [7:0] CH_ADDR =
				8'(PAC_CHAN_BASE + PAC_CHAN_STRIDE * gi);
			assign chan_hit[gi] = (reg_addr_i == CH_ADDR);
			always_comb begin
				next_value[gi] = s.value[gi];
				if (!s.dir[gi] && capture_strobe_i[gi]) begin
					next_value[gi] = timer_count_i;
				end else if (s.dir[gi] && reg_wr_i && chan_hit[gi]) begin
					next_value[gi] = reg_wdata_i;
				end
			end
		end
	endgenerate

	always_comb begin
		next_s = s;
		next_s.sync1 = channel7_pin_i;
		next_s.sync2 = s.sync1;
		next_s.pin_prev = s.sync2;
		next_s.value = next_value;
		next_s.flags = (s.flags & ~flag_clr) | flag_set; // set wins
		if (count_wr) begin
			next_s.count = reg_wdata_i;
		end else if (accum_clock) begin
			next_s.count = s.count + PAC_ONE;
		end
		if (accum_clock) begin
			next_s.div_cnt = s.div_cnt + PAC_ONE;
		end
		if (reg_wr_i) begin
			case (reg_addr_i)
			PAC_CTRL_ADDR: next_s.ctrl = reg_wdata_i[7:0] & PAC_CTRL_MASK;
			PAC_DIR_ADDR: next_s.dir = reg_wdata_i[NUM_CH-1:0];
			PAC_TSC_ADDR: begin
				next_s.main_timer_enable = reg_wdata_i[PAC_TEN_BIT];
				next_s.fast_flag_clear = reg_wdata_i[PAC_FFCA_BIT];
			end
			default: ;
			endcase
		end
		// read data stand for exactly one cycle after the strobe
		next_s.rdata = '0;
		if (reg_rd_i) begin
			case (reg_addr_i)
			PAC_CTRL_ADDR: next_s.rdata[7:0] = s.ctrl & PAC_CTRL_MASK;
			PAC_FLAG_ADDR: next_s.rdata[1:0] = s.flags;
			PAC_COUNT_ADDR: next_s.rdata = s.count;
			PAC_DIR_ADDR: next_s.rdata[NUM_CH-1:0] = s.dir;
			PAC_TSC_ADDR: begin
				next_s.rdata[PAC_TEN_BIT] = s.main_timer_enable;
				next_s.rdata[PAC_FFCA_BIT] = s.fast_flag_clear;
			end
			default: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (chan_hit[i]) begin
						next_s.rdata = s.value[i];
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_o = s.rdata;
	assign channel_value_o = s.value;
	assign channel_direction_o = s.dir;
	assign main_timer_enable_o = s.main_timer_enable;
	assign accum_clock_o = accum_clock;
	assign irq_o = (s.flags[PAC_OVF_BIT] & s.ctrl[PAC_OVF_IE_BIT]) |
		(s.flags[PAC_IN_BIT] & s.ctrl[PAC_IN_IE_BIT]);

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_capture_loads: assert property (
		!s.dir[0] && capture_strobe_i[0] |=> s.value[0] == $past(timer_count_i))
		else $error("capture did not load the counter value");
	a_ic_write_ignored: assert property (
		!s.dir[1] && reg_wr_i && chan_hit[1] && !capture_strobe_i[1]
		|=> $stable(s.value[1]))
		else $error("value write during input capture took effect");
	a_oc_write_taken: assert property (
		s.dir[1] && reg_wr_i && chan_hit[1] |=> s.value[1] == $past(reg_wdata_i))
		else $error("compare value write was lost");
	a_reset_values: assert property (@(posedge core_clk_i) disable iff (1'b0)
		!rst_n_i |=> s.value == '0 && s.ctrl == PAC_CTRL_RESET)
		else $error("registers not zero after reset");
	a_disabled_hold: assert property (
		!accum_enable && !count_wr |=> $stable(s.count))
		else $error("count moved while accumulator disabled");
	a_event_edge: assert property (
		accum_enable && !accum_mode_select && !accum_polarity && !count_wr
		&& s.sync2 ##1 !s.sync2 |=> s.count == $past(s.count) + PAC_ONE)
		else $error("falling edge not counted");
	a_gate_no_timer: assert property (
		!s.main_timer_enable && accum_mode_select |-> !accum_clock)
		else $error("gated clock ran with the timer disabled");
	a_overflow_flag: assert property (
		overflow |=> s.flags[PAC_OVF_BIT] && s.count == '0)
		else $error("wrap did not set overflow flag");
	a_fast_clear: assert property (
		s.fast_flag_clear && count_access && !overflow && !flag_set[PAC_IN_BIT]
		|=> s.flags == 2'b00)
		else $error("count access did not clear flags");
	a_irq_level: assert property (
		s.flags[PAC_OVF_BIT] && s.ctrl[PAC_OVF_IE_BIT] ##0 1 |-> irq_o)
		else $error("overflow interrupt not requested");
	a_clksel_disabled: assert property (
		!accum_enable |-> timer_count_tick_o == prescale_tick_i)
		else $error("disabled accumulator did not use prescaler clock");
	a_read_latency: assert property (
		reg_rd_i && reg_addr_i == PAC_COUNT_ADDR |=> reg_rdata_o == $past(s.count))
		else $error("count read data wrong");

	// extra guards on counting, flags, interrupts, the clock selector, register writes, captures and read data
	a_rise_count: assert property (
		accum_enable && !accum_mode_select && accum_polarity && pin_rise
		&& !count_wr |=> s.count == $past(s.count) + PAC_ONE)
		else $error("rising edge not counted");
	a_gated_count: assert property (
		accum_enable && accum_mode_select && gate_active && div64_tick_i
		&& s.main_timer_enable && !count_wr |=> s.count == $past(s.count) + PAC_ONE)
		else $error("gated tick not counted");
	a_gate_idle: assert property (
		accum_enable && accum_mode_select && !gate_active && !count_wr
		|=> $stable(s.count))
		else $error("count moved with gate inactive");
	a_gate_trail_flag: assert property (
		accum_enable && accum_mode_select && accum_polarity && pin_rise
		|=> s.flags[PAC_IN_BIT])
		else $error("trailing gate edge did not set input flag");
	a_event_flag: assert property (
		accum_enable && !accum_mode_select && !accum_polarity && pin_fall
		|=> s.flags[PAC_IN_BIT])
		else $error("event edge did not set input flag");
	a_input_clear: assert property (
		reg_wr_i && reg_addr_i == PAC_FLAG_ADDR && reg_wdata_i[PAC_IN_BIT]
		&& !flag_set[PAC_IN_BIT] |=> !s.flags[PAC_IN_BIT])
		else $error("input flag not cleared by write one");
	a_ovf_clear: assert property (
		reg_wr_i && reg_addr_i == PAC_FLAG_ADDR && reg_wdata_i[PAC_OVF_BIT]
		&& !flag_set[PAC_OVF_BIT] |=> !s.flags[PAC_OVF_BIT])
		else $error("overflow flag not cleared by write one");
	a_disabled_no_flag: assert property (
		!accum_enable && !s.flags[PAC_IN_BIT]
		|=> !s.flags[PAC_IN_BIT])
		else $error("input flag set while accumulator disabled");
	a_disabled_no_clk: assert property (
		!accum_enable
		|-> !accum_clock)
		else $error("accumulator clock ran while disabled");
	a_irq_input: assert property (
		s.flags[PAC_IN_BIT] && s.ctrl[PAC_IN_IE_BIT]
		|-> irq_o)
		else $error("input interrupt not requested");
	a_irq_masked: assert property (
		!(s.flags[PAC_OVF_BIT] && s.ctrl[PAC_OVF_IE_BIT])
		&& !(s.flags[PAC_IN_BIT] && s.ctrl[PAC_IN_IE_BIT]) |-> !irq_o)
		else $error("interrupt raised while inhibited");
	a_clksel_accum: assert property (
		accum_enable && clksel == PAC_CLK_ACCUM
		|-> timer_count_tick_o == accum_clock)
		else $error("accumulator clock not selected");
	a_clksel_div256: assert property (
		accum_enable && clksel == PAC_CLK_DIV256
		|-> timer_count_tick_o == tick256)
		else $error("divided-by-256 clock not selected");
	a_clksel_div65536: assert property (
		accum_enable && clksel == PAC_CLK_DIV65536
		|-> timer_count_tick_o == tick65536)
		else $error("divided-by-65536 clock not selected");
	a_clksel_switch: assert property (
		reg_wr_i && reg_addr_i == PAC_CTRL_ADDR && reg_wdata_i[PAC_EN_BIT]
		&& reg_wdata_i[PAC_CLK_HI:PAC_CLK_LO] == PAC_CLK_ACCUM
		|=> timer_count_tick_o == accum_clock)
		else $error("clock select did not switch at once");
	a_count_write: assert property (
		count_wr
		|=> s.count == $past(reg_wdata_i))
		else $error("count write lost");
	a_tsc_write: assert property (
		reg_wr_i && reg_addr_i == PAC_TSC_ADDR
		|=> s.main_timer_enable == $past(reg_wdata_i[PAC_TEN_BIT]))
		else $error("timer enable write lost");
	a_dir_write: assert property (
		reg_wr_i && reg_addr_i == PAC_DIR_ADDR
		|=> s.dir == $past(reg_wdata_i[NUM_CH-1:0]))
		else $error("direction write lost");
	a_chan7_capture: assert property (
		!s.dir[NUM_CH-1] && capture_strobe_i[NUM_CH-1]
		|=> s.value[NUM_CH-1] == $past(timer_count_i))
		else $error("channel 7 capture did not load the counter");
	a_oc_no_capture: assert property (
		s.dir[0] && capture_strobe_i[0] && !(reg_wr_i && chan_hit[0])
		|=> $stable(s.value[0]))
		else $error("compare value overwritten by capture");
	a_rdata_idle: assert property (
		!reg_rd_i
		|=> reg_rdata_o == '0)
		else $error("read data did not return to zero");
	a_rdata_ctrl: assert property (
		reg_rd_i && reg_addr_i == PAC_CTRL_ADDR
		|=> reg_rdata_o == {8'h00, $past(s.ctrl) & PAC_CTRL_MASK})
		else $error("control read data wrong");
	a_rdata_flags: assert property (
		reg_rd_i && reg_addr_i == PAC_FLAG_ADDR
		|=> reg_rdata_o[1:0] == $past(s.flags))
		else $error("flag read data wrong");

	c_overflow: cover property (overflow);
	c_gated_count: cover property (accum_mode_select && accum_clock);
	c_div256_tick: cover property (accum_enable && clksel == PAC_CLK_DIV256
		&& tick256);
	c_set_clear_race: cover property (|(flag_set & flag_clr));
	c_fast_clear: cover property (s.fast_flag_clear && count_access);
endmodule : pac_accum
`default_nettype wire

// *** logic/pac_pkg.sv ***
/*
 * pac_pkg: register map, field positions and clock-select codes of the
 * pulse accumulator control block.
 * Assumes a byte-addressed register port carrying 16-bit data words.
 */
`default_nettype none
package pac_pkg;
	localparam int PAC_VAL_W = 16;
	localparam int PAC_ADDR_W = 8;
	localparam int PAC_DIV256_W = 8;

	// register addresses
	localparam logic [7:0] PAC_DIR_ADDR = 8'h00;
	localparam logic [7:0] PAC_TSC_ADDR = 8'h06;
	localparam logic [7:0] PAC_CHAN_BASE = 8'h10;
	localparam logic [7:0] PAC_CHAN_STRIDE = 8'h02;
	localparam logic [7:0] PAC_CTRL_ADDR = 8'h20;
	localparam logic [7:0] PAC_FLAG_ADDR = 8'h21;
	localparam logic [7:0] PAC_COUNT_ADDR = 8'h22;

	// accum_control fields
	localparam int PAC_EN_BIT = 6;
	localparam int PAC_MODE_BIT = 5;
	localparam int PAC_POL_BIT = 4;
	localparam int PAC_CLK_HI = 3;
	localparam int PAC_CLK_LO = 2;
	localparam int PAC_OVF_IE_BIT = 1;
	localparam int PAC_IN_IE_BIT = 0;
	localparam logic [7:0] PAC_CTRL_MASK = 8'h7f;

	// accum_flag_register fields
	localparam int PAC_OVF_BIT = 1;
	localparam int PAC_IN_BIT = 0;

	// timer_system_control fields
	localparam int PAC_TEN_BIT = 7;
	localparam int PAC_FFCA_BIT = 4;

	localparam logic [7:0] PAC_CTRL_RESET = 8'h00;
	localparam logic [15:0] PAC_VALUE_RESET = 16'h0000;
	localparam logic [15:0] PAC_COUNT_MAX = 16'hffff;
	localparam logic [15:0] PAC_ONE = 16'h0001;
	localparam logic [7:0] PAC_DIV256_MAX = 8'hff;

	typedef enum logic [1:0] {
		PAC_CLK_PRESCALE = 2'b00,
		PAC_CLK_ACCUM = 2'b01,
		PAC_CLK_DIV256 = 2'b10,
		PAC_CLK_DIV65536 = 2'b11
	} pac_clksel_type;
endpackage : pac_pkg
`default_nettype wire

// *** verification/pac_pin_model.sv ***
/*
 * pac_pin_model: external digital source on the shared channel 7 pin.
 * Assumes the bench calls its tasks; levels last > 2 bus clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module pac_pin_model (
	input wire logic core_clk_i,
	output var logic channel7_pin_o
);
	initial channel7_pin_o = 1'b0;

	// hold each level 4 clocks so the two-flop sync never drops it
	task automatic set_level(input logic v);
		@(posedge core_clk_i);
		channel7_pin_o <= v;
		repeat (4) @(posedge core_clk_i);
	endtask : set_level

	task automatic pulse(input logic idle);
		set_level(~idle);
		set_level(idle);
	endtask : pulse
endmodule : pac_pin_model
`default_nettype wire

// *** verification/tb_top.sv ***
/*
 * tb_top: register-level tests of pac_accum.
 * Assumes the one-cycle strobe register port and pac_pin_model on the pin.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import pac_pkg::*;
	logic clk, rst_n, wr, rd, pin, pre, d64;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, got;
	logic [7:0] cap;
	logic tick, aclk, irq, mten;
	logic [15:0] tcount;
	logic [127:0] chval;
	logic [7:0] chdir;
	int errors = 0;
	int total_checks = 0;

	pac_accum uut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .channel7_pin_i(pin), .prescale_tick_i(pre),
		.div64_tick_i(d64), .timer_count_i(tcount),
		.capture_strobe_i(cap), .channel_value_o(chval),
		.channel_direction_o(chdir), .main_timer_enable_o(mten),
		.timer_count_tick_o(tick), .accum_clock_o(aclk), .irq_o(irq));
	pac_pin_model pin_src (.core_clk_i(clk), .channel7_pin_o(pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [15:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(what, exp, rdata);
	endtask : rd_chk

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			d64 <= 1'b1;
			@(posedge clk);
			d64 <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask : ticks

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end

	initial begin
		{rst_n, wr, rd, pre, d64, cap, addr, wdata, tcount} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("ctrl", PAC_CTRL_ADDR, 16'h0000);
		rd_chk("ch0", PAC_CHAN_BASE, 16'h0000);
		wr_reg(PAC_CTRL_ADDR, 16'h00ff);
		rd_chk("ctrl", PAC_CTRL_ADDR, 16'h007f);
		// capture channel: writes dropped, strobe loads counter
		wr_reg(PAC_CHAN_BASE, 16'h1234);
		rd_chk("ch0", PAC_CHAN_BASE, 16'h0000);
		@(posedge clk) begin
			cap <= 8'h01;
			tcount <= 16'hbeef;
		end
		@(posedge clk) begin
			cap <= 8'h00;
			tcount <= 16'h0000;
		end
		rd_chk("ch0", PAC_CHAN_BASE, 16'hbeef);
		chk("chval0", 16'hbeef, chval[15:0]);
		wr_reg(PAC_DIR_ADDR, 16'h0001);
		#1 chk("dir", 16'h0001, {8'h00, chdir});
		wr_reg(PAC_CHAN_BASE, 16'h1234);
		rd_chk("ch0", PAC_CHAN_BASE, 16'h1234);
		// disabled accumulator keeps prescaler clock whatever clksel
		wr_reg(PAC_CTRL_ADDR, 16'h0004);
		@(posedge clk) pre <= 1'b1;
		#1 chk("tick", 16'h0001, {15'h0, tick});
		wr_reg(PAC_CTRL_ADDR, 16'h0044);
		#1 chk("tick", 16'h0000, {15'h0, tick});
		pre <= 1'b0;
		// rising-edge events with input interrupt, timer off
		wr_reg(PAC_CTRL_ADDR, 16'h0051);
		wr_reg(PAC_COUNT_ADDR, 16'h0000);
		wr_reg(PAC_FLAG_ADDR, 16'h0003);
		repeat (3) pin_src.pulse(1'b0);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0003);
		rd_chk("flags", PAC_FLAG_ADDR, 16'h0001);
		chk("irq", 16'h0001, {15'h0, irq});
		wr_reg(PAC_FLAG_ADDR, 16'h0001);
		#1 chk("irq", 16'h0000, {15'h0, irq});
		// falling polarity: rise ignored, fall counted
		wr_reg(PAC_CTRL_ADDR, 16'h0040);
		pin_src.set_level(1'b1);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0003);
		pin_src.set_level(1'b0);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0004);
		// wrap sets overflow and its interrupt
		wr_reg(PAC_CTRL_ADDR, 16'h0052);
		wr_reg(PAC_COUNT_ADDR, 16'hffff);
		wr_reg(PAC_FLAG_ADDR, 16'h0003);
		pin_src.pulse(1'b0);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0000);
		rd_chk("flags", PAC_FLAG_ADDR, 16'h0003);
		chk("irq", 16'h0001, {15'h0, irq});
		wr_reg(PAC_FLAG_ADDR, 16'h0002);
		#1 chk("irq", 16'h0000, {15'h0, irq});
		// gated by high level, timer running
		wr_reg(PAC_TSC_ADDR, 16'h0080);
		#1 chk("ten", 16'h0001, {15'h0, mten});
		wr_reg(PAC_CTRL_ADDR, 16'h0060);
		wr_reg(PAC_FLAG_ADDR, 16'h0003);
		pin_src.set_level(1'b1);
		ticks(5);
		pin_src.set_level(1'b0);
		ticks(2);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0005);
		rd_chk("flags", PAC_FLAG_ADDR, 16'h0001);
		// no gated clock while timer disabled
		wr_reg(PAC_TSC_ADDR, 16'h0000);
		#1 chk("ten", 16'h0000, {15'h0, mten});
		pin_src.set_level(1'b1);
		ticks(3);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0005);
		// fast clear: count access drops both flags
		pin_src.set_level(1'b0);
		wr_reg(PAC_TSC_ADDR, 16'h0010);
		rd_chk("count", PAC_COUNT_ADDR, 16'h0005);
		rd_chk("flags", PAC_FLAG_ADDR, 16'h0000);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
